/* File: logic/hub_cfg_pkg.sv */
// Purpose: shared constants for the host bus configuration block
// Assumes: 40 MHz core clock, 32-bit Avalon-MM register port
// Notes:   36-bit processor addresses
package hub_cfg_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_CFG    = 5'h00;
  localparam logic [4:0] OFS_STAT   = 5'h04;
  localparam logic [4:0] OFS_MASK   = 5'h08;
  localparam logic [4:0] OFS_LIMIT  = 5'h0C;
  localparam logic [4:0] OFS_SLICE  = 5'h10;
  localparam logic [4:0] OFS_RSTCTL = 5'h14;

  // field positions in the configuration register
  localparam int BIT_THR    = 4;
  localparam int BIT_IN_ORDER_QUEUE_DEPTH_BIT   = 2;
  localparam int BIT_FIXCTL = 1;

  // event bits of status and mask
  localparam int EV_THR   = 0;
  localparam int EV_STRAP = 1;
  localparam int EV_W     = 2;

  // values after reset
  localparam logic [7:0]  LIMIT_RST = 8'h04;
  localparam logic [15:0] SLICE_RST = 16'h0100;

  // processor reset hold time
  localparam int CLK_PERIOD_NS   = 25;
  localparam int CPU_RST_TIME_NS = 1000;
  localparam int CPU_RST_CYCLES  = (CPU_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // interrupt-controller windows
  localparam logic [35:0] WIN_A_LO = 36'h0_FEC0_0000;
  localparam logic [35:0] WIN_A_HI = 36'h0_FEC7_FFFF;
  localparam logic [35:0] WIN_B    = 36'h0_FEC8_0000;
  localparam logic [35:0] WIN_C    = 36'h0_FEC8_1000;
  localparam logic [35:0] WIN_D    = 36'h0_FEC8_2000;

  // hub link codes
  localparam logic [1:0] LINK_A = 2'h0;
  localparam logic [1:0] LINK_B = 2'h1;
  localparam logic [1:0] LINK_C = 2'h2;
  localparam logic [1:0] LINK_D = 2'h3;

  typedef enum logic {RS_HOLD, RS_RUN} rst_state_t;

endpackage

/* File: logic/intc_route.sv */
// Purpose: steers one processor access to a hub link
// Assumes: purely combinational, caller registers the result
// Notes:   fixed windows apply only while fixed routing is selected
`timescale 1ns/1ps
module intc_route (
  input  wire logic [35:0] addr_i,
  input  wire logic        fixed_route_i,
  input  wire logic [1:0]  decode_link_i,
  output logic      [1:0]  link_o,
  output logic             win_hit_o
);

  function automatic logic in_4k(input logic [35:0] a, input logic [35:0] base);
    in_4k = (a[35:12] == base[35:12]);
  endfunction

  always_comb begin
    link_o    = decode_link_i;
    win_hit_o = 1'b0;
    if (fixed_route_i) begin
      if (addr_i >= hub_cfg_pkg::WIN_A_LO && addr_i <= hub_cfg_pkg::WIN_A_HI) begin
        link_o    = hub_cfg_pkg::LINK_A; // RULE6
        win_hit_o = 1'b1;
      end else if (in_4k(addr_i, hub_cfg_pkg::WIN_B)) begin
        link_o    = hub_cfg_pkg::LINK_B; // RULE7
        win_hit_o = 1'b1;
      end else if (in_4k(addr_i, hub_cfg_pkg::WIN_C)) begin
        link_o    = hub_cfg_pkg::LINK_C; // RULE7
        win_hit_o = 1'b1;
      end else if (in_4k(addr_i, hub_cfg_pkg::WIN_D)) begin
        link_o    = hub_cfg_pkg::LINK_D; // RULE7
        win_hit_o = 1'b1;
      end
    end
  end

endmodule

/* File: logic/host_bus_cfg.sv */
// Purpose: host bus configuration/status register with routing control
// Assumes: one clock, synchronous active-low reset, Avalon-MM slave
// Notes:   one wait state on every register access
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// (RULE1) The throttle flag sets when the slice write limit is reached and another write waits.
// (RULE2) Software clears the throttle flag by writing zero to its bit.
// (RULE3) The queue depth bit captures the strap pin as the processor reset is released.
// (RULE4) A low strap gives a depth bit of one, meaning a twelve-deep queue.
// (RULE5) A high strap gives a depth bit of zero, meaning no pipelining.
// (RULE6) With fixed routing, FEC0_0000 to FEC7_FFFF go to hub link A.
// (RULE7) With fixed routing, the 4 KB windows at FEC8_0000, _1000, _2000 go to links B, C, D.
// (RULE8) With the other setting, interrupt-controller accesses follow the general decode.
// (RULE9) The throttle flag stays set until cleared, and writing one leaves it alone.
module host_bus_cfg (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        wr_done_i,
  input  wire logic        wr_pending_i,
  input  wire logic        queue_depth_strap_pin_i,
  output logic             processor_reset_out_n_o,
  input  wire logic        acc_valid_i,
  input  wire logic [35:0] acc_addr_i,
  input  wire logic [1:0]  acc_decode_link_i,
  output logic             link_valid_o,
  output logic      [1:0]  link_sel_o,
  output logic             win_hit_o,
  output logic             throttle_active_o,
  output logic             irq_o
);

  typedef struct packed {
    hub_cfg_pkg::rst_state_t rs;
    logic [7:0]              rst_cnt;
    logic                    fix_ctl;
    logic                    thr_flag;
    logic                    in_order_queue_depth_bit;
    logic [1:0]              stat;
    logic [1:0]              mask;
    logic [7:0]              wr_limit;
    logic [15:0]             slice_len;
    logic [15:0]             slice_cnt;
    logic [7:0]              wr_cnt;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    link_valid;
    logic [1:0]              link_sel;
    logic                    win_hit;
  } st_t;

  localparam logic [7:0] RST_LAST = 8'(hub_cfg_pkg::CPU_RST_CYCLES - 1);

  st_t st_ff;
  st_t nxt_st;

  logic       req;
  logic       commit_wr;
  logic       commit_rd;
  logic       slice_tick;
  logic       limit_hit;
  logic       thr_set;
  logic       strap_take;
  logic       cfg_wr;
  logic [1:0] route_link;
  logic       route_hit;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic [31:0] cfg_word(input st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[hub_cfg_pkg::BIT_THR]    = s.thr_flag;
    w[hub_cfg_pkg::BIT_IN_ORDER_QUEUE_DEPTH_BIT]   = s.in_order_queue_depth_bit;
    w[hub_cfg_pkg::BIT_FIXCTL] = s.fix_ctl;
    cfg_word = w;
  endfunction

  // control bit low selects the fixed windows
  intc_route u_route (
    .addr_i        (acc_addr_i),
    .fixed_route_i (~st_ff.fix_ctl),
    .decode_link_i (acc_decode_link_i),
    .link_o        (route_link),
    .win_hit_o     (route_hit)
  );

  assign req        = avs_read_i | avs_write_i;
  assign commit_wr  = avs_write_i & st_ff.ack;
  assign commit_rd  = avs_read_i & st_ff.ack;
  assign slice_tick = (st_ff.slice_cnt >= st_ff.slice_len);
  assign limit_hit  = (st_ff.wr_cnt >= st_ff.wr_limit);
  assign thr_set    = limit_hit & wr_pending_i; // RULE1
  assign strap_take = (st_ff.rs == hub_cfg_pkg::RS_HOLD) && (st_ff.rst_cnt == RST_LAST);
  assign cfg_wr     = commit_wr && (avs_address_i == hub_cfg_pkg::OFS_CFG);

  always_comb begin
    logic [31:0] m;
    m      = 32'h0000_0000;
    nxt_st = st_ff;

    // bus handshake: one wait state, then the access completes
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      unique case (avs_address_i)
        hub_cfg_pkg::OFS_CFG:    nxt_st.rdata = cfg_word(st_ff);
        hub_cfg_pkg::OFS_STAT:   nxt_st.rdata = {30'h0000_0000, st_ff.stat};
        hub_cfg_pkg::OFS_MASK:   nxt_st.rdata = {30'h0000_0000, st_ff.mask};
        hub_cfg_pkg::OFS_LIMIT:  nxt_st.rdata = {24'h00_0000, st_ff.wr_limit};
        hub_cfg_pkg::OFS_SLICE:  nxt_st.rdata = {16'h0000, st_ff.slice_len};
        hub_cfg_pkg::OFS_RSTCTL: begin
          nxt_st.rdata = {31'h0000_0000, st_ff.rs == hub_cfg_pkg::RS_HOLD};
        end
        default:                 nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // processor reset sequencing and strap capture
    unique case (st_ff.rs)
      hub_cfg_pkg::RS_HOLD: begin
        nxt_st.rst_cnt = st_ff.rst_cnt + 8'h01;
        if (strap_take) begin
          nxt_st.rs      = hub_cfg_pkg::RS_RUN;
          nxt_st.rst_cnt = 8'h00;
          nxt_st.in_order_queue_depth_bit    = ~queue_depth_strap_pin_i; // RULE3 RULE4 RULE5
        end
      end
      hub_cfg_pkg::RS_RUN: begin
        nxt_st.rst_cnt = 8'h00;
      end
    endcase

    // write slice timer and per-slice write count
    if (slice_tick) begin
      nxt_st.slice_cnt = 16'h0000;
      nxt_st.wr_cnt    = 8'h00;
    end else begin
      nxt_st.slice_cnt = st_ff.slice_cnt + 16'h0001;
      if (wr_done_i && st_ff.wr_cnt != 8'hFF) begin
        nxt_st.wr_cnt = st_ff.wr_cnt + 8'h01;
      end
    end

    // register writes
    if (commit_wr) begin
      unique case (avs_address_i)
        hub_cfg_pkg::OFS_CFG: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.fix_ctl = avs_writedata_i[hub_cfg_pkg::BIT_FIXCTL];
            if (!avs_writedata_i[hub_cfg_pkg::BIT_THR]) begin
              nxt_st.thr_flag = 1'b0; // RULE2
            end
          end
        end
        hub_cfg_pkg::OFS_STAT: begin
          if (avs_byteenable_i[0]) begin
            nxt_st.stat = st_ff.stat & ~avs_writedata_i[1:0];
          end
        end
        hub_cfg_pkg::OFS_MASK: begin
          m           = merge({30'h0000_0000, st_ff.mask}, avs_writedata_i, avs_byteenable_i);
          nxt_st.mask = m[1:0];
        end
        hub_cfg_pkg::OFS_LIMIT: begin
          m               = merge({24'h00_0000, st_ff.wr_limit}, avs_writedata_i,
                                  avs_byteenable_i);
          nxt_st.wr_limit = m[7:0];
        end
        hub_cfg_pkg::OFS_SLICE: begin
          m                = merge({16'h0000, st_ff.slice_len}, avs_writedata_i,
                                   avs_byteenable_i);
          nxt_st.slice_len = m[15:0];
        end
        hub_cfg_pkg::OFS_RSTCTL: begin
          if (avs_byteenable_i[0] && avs_writedata_i[0]) begin
            nxt_st.rs      = hub_cfg_pkg::RS_HOLD;
            nxt_st.rst_cnt = 8'h00;
          end
        end
        default: begin
          nxt_st.rdata = st_ff.rdata;
        end
      endcase
    end

    // hardware sets win over software clears
    if (thr_set) begin
      nxt_st.thr_flag           = 1'b1; // RULE1 RULE9
      nxt_st.stat[hub_cfg_pkg::EV_THR] = 1'b1;
    end
    if (strap_take) begin
      nxt_st.stat[hub_cfg_pkg::EV_STRAP] = 1'b1;
    end

    // access routing
    nxt_st.link_valid = acc_valid_i;
    if (acc_valid_i) begin
      nxt_st.link_sel = route_link; // RULE6 RULE7 RULE8
      nxt_st.win_hit  = route_hit;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_ff           <= '0;
      st_ff.rs        <= hub_cfg_pkg::RS_HOLD;
      st_ff.wr_limit  <= hub_cfg_pkg::LIMIT_RST;
      st_ff.slice_len <= hub_cfg_pkg::SLICE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata_o          = st_ff.rdata;
  assign avs_waitrequest_o       = req & ~st_ff.ack;
  assign processor_reset_out_n_o = (st_ff.rs == hub_cfg_pkg::RS_RUN);
  assign link_valid_o            = st_ff.link_valid;
  assign link_sel_o              = st_ff.link_sel;
  assign win_hit_o               = st_ff.win_hit;
  assign throttle_active_o       = limit_hit;
  assign irq_o                   = |(st_ff.stat & st_ff.mask);

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // window decodes rebuilt here so the checks do not lean on the router
  logic in_a;
  logic in_b;
  logic in_c;
  logic in_d;
  assign in_a = acc_addr_i >= hub_cfg_pkg::WIN_A_LO && acc_addr_i <= hub_cfg_pkg::WIN_A_HI;
  assign in_b = acc_addr_i[35:12] == hub_cfg_pkg::WIN_B[35:12];
  assign in_c = acc_addr_i[35:12] == hub_cfg_pkg::WIN_C[35:12];
  assign in_d = acc_addr_i[35:12] == hub_cfg_pkg::WIN_D[35:12];

  chk_thr_set_flag: assert property ( // RULE1
    st_ff.wr_cnt >= st_ff.wr_limit && wr_pending_i |=> st_ff.thr_flag && st_ff.stat[0])
    else $error("throttle flag not set at write limit");

  chk_thr_zero_clear: assert property ( // RULE2
    cfg_wr && avs_byteenable_i[0] && !avs_writedata_i[4] && !thr_set |=> !st_ff.thr_flag)
    else $error("throttle flag not cleared by zero write");

  chk_thr_sticky_hold: assert property ( // RULE9
    st_ff.thr_flag && !(cfg_wr && !avs_writedata_i[4]) |=> st_ff.thr_flag)
    else $error("throttle flag dropped without a clear");

  chk_in_order_queue_depth_bit_stable_run: assert property ( // RULE3
    processor_reset_out_n_o && $past(processor_reset_out_n_o) |-> $stable(st_ff.in_order_queue_depth_bit))
    else $error("depth bit changed while processor runs");

  chk_in_order_queue_depth_bit_low_strap: assert property ( // RULE4
    $rose(processor_reset_out_n_o) && !$past(queue_depth_strap_pin_i) |-> st_ff.in_order_queue_depth_bit)
    else $error("low strap did not give depth bit one");

  chk_in_order_queue_depth_bit_high_strap: assert property ( // RULE5
    $rose(processor_reset_out_n_o) && $past(queue_depth_strap_pin_i) |-> !st_ff.in_order_queue_depth_bit)
    else $error("high strap did not give depth bit zero");

  chk_route_link_a: assert property ( // RULE6
    acc_valid_i && !st_ff.fix_ctl && in_a |=> link_valid_o && link_sel_o == 2'h0)
    else $error("fixed window A misrouted");

  chk_route_link_bd: assert property ( // RULE7
    acc_valid_i && !st_ff.fix_ctl && (in_b || in_d)
      |=> link_sel_o == ($past(in_b) ? 2'h1 : 2'h3) && win_hit_o)
    else $error("fixed window B or D misrouted");

  chk_route_decode_on: assert property ( // RULE8
    acc_valid_i && st_ff.fix_ctl |=> link_sel_o == $past(acc_decode_link_i) && !win_hit_o)
    else $error("decode setting ignored general decode");

  chk_bus_one_wait: assert property (
    req && !st_ff.ack |=> !avs_waitrequest_o)
    else $error("bus answer late");

  // window C checked on its own so a swapped B/C decode cannot hide
  chk_route_link_c: assert property ( // RULE7
    acc_valid_i && !st_ff.fix_ctl && in_c
      |=> link_sel_o == hub_cfg_pkg::LINK_C && win_hit_o)
    else $error("fixed window C misrouted");

  // outside every window the fixed setting still follows the general decode
  chk_route_miss_dec: assert property (
    acc_valid_i && !st_ff.fix_ctl && !(in_a || in_b || in_c || in_d)
      |=> link_sel_o == $past(acc_decode_link_i) && !win_hit_o)
    else $error("non-window access not on general decode");

  chk_link_valid_dly: assert property (
    link_valid_o == $past(acc_valid_i))
    else $error("link valid not one cycle behind access");

  // status bits clear on a written one unless hardware sets them in the same cycle
  chk_stat_w1c: assert property (
    commit_wr && avs_address_i == hub_cfg_pkg::OFS_STAT && avs_byteenable_i[0]
      && avs_writedata_i[hub_cfg_pkg::EV_STRAP] && !strap_take
      |=> !st_ff.stat[hub_cfg_pkg::EV_STRAP])
    else $error("status bit survived a write of one");

  chk_stat_sticky: assert property (
    st_ff.stat[hub_cfg_pkg::EV_THR]
      && !(commit_wr && avs_address_i == hub_cfg_pkg::OFS_STAT) |=> st_ff.stat[hub_cfg_pkg::EV_THR])
    else $error("throttle event dropped without a clear");

  // a full-lane slice write lands at the completing edge
  chk_slice_write: assert property (
    commit_wr && avs_address_i == hub_cfg_pkg::OFS_SLICE && avs_byteenable_i[1:0] == 2'h3
      |=> st_ff.slice_len == $past(avs_writedata_i[15:0]))
    else $error("slice length write lost");

  // the depth bit is read-only: register writes never move it
  chk_in_order_queue_depth_bit_ro_write: assert property ( // RULE3
    cfg_wr && !strap_take |=> $stable(st_ff.in_order_queue_depth_bit))
    else $error("depth bit moved by a register write");

  // processor reset stays low for the whole hold time before each release
  chk_cpu_rst_hold: assert property (
    $rose(processor_reset_out_n_o)
      |-> !$past(processor_reset_out_n_o, hub_cfg_pkg::CPU_RST_CYCLES))
    else $error("processor reset released too early");

  cov_thr_rise:   cover property ($rose(st_ff.thr_flag));
  cov_rst_done:   cover property ($rose(processor_reset_out_n_o));
  cov_route_d:    cover property (acc_valid_i && !st_ff.fix_ctl && in_d);
  cov_irq_raise:  cover property ($rose(irq_o));
  cov_strap_high: cover property ($rose(processor_reset_out_n_o) && $past(queue_depth_strap_pin_i));

endmodule

/* File: testbench/hub_far_side.sv */
// Purpose: far-side model: processor bus writes, strap pin, access stream
// Assumes: every output changes just after a rising edge of ref_clk_i
// Notes:   idle address and link lines show the inverse of the last value
`timescale 1ns/1ps
module hub_far_side (
  input  wire logic        ref_clk_i,
  output logic             wr_done_o,
  output logic             wr_pending_o,
  output logic             strap_o,
  output logic             acc_valid_o,
  output logic      [35:0] acc_addr_o,
  output logic      [1:0]  acc_link_o
);
  initial begin
    wr_done_o = 1'b0;
    wr_pending_o = 1'b0;
    strap_o = 1'b0;
    acc_valid_o = 1'b0;
    acc_addr_o = 36'h0;
    acc_link_o = 2'h0;
  end

  // one completed write per pulse
  task automatic writes(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      wr_done_o <= 1'b1;
      @(posedge ref_clk_i);
      wr_done_o <= 1'b0;
    end
  endtask

  task automatic set_pending(input logic v);
    @(posedge ref_clk_i);
    wr_pending_o <= v;
  endtask

  task automatic set_strap(input logic v);
    @(posedge ref_clk_i);
    strap_o <= v;
  endtask

  task automatic access(input logic [35:0] a, input logic [1:0] l);
    @(posedge ref_clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= a;
    acc_link_o <= l;
    @(posedge ref_clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o <= ~a;
    acc_link_o <= ~l;
  endtask
endmodule

/* File: testbench/host_bus_cfg_apic_routing_tb_top.sv */
// Purpose: register, throttle, strap capture and routing checks
// Assumes: strap low at first reset, bus answer time taken from waitrequest
// Notes:   routing table runs in both settings of the range control
`timescale 1ns/1ps
module host_bus_cfg_apic_routing_tb_top;
  logic        ref_clk_i;
  logic        nrst_i;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [3:0]  be_sel;
  logic [31:0] rdat;
  logic        wreq;
  logic        done;
  logic        pend;
  logic        strap;
  logic        cpu_rst_n;
  logic        av;
  logic [35:0] aa;
  logic [1:0]  al;
  logic        link_valid;
  logic [1:0]  link_sel;
  logic        win_hit;
  logic        thr;
  logic        irq;
  int          error_cnt;
  int          tests_run;
  logic [35:0] ta [9] = '{36'h0_FEC0_0000, 36'h0_FEC7_FFFF, 36'h0_FEC8_0000, 36'h0_FEC8_0FFF,
                          36'h0_FEC8_1000, 36'h0_FEC8_1FFF, 36'h0_FEC8_2FFF, 36'h0_FEC8_3000,
                          36'h0_FEBF_FFFF};
  logic [1:0]  tl [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1};
  logic        th [9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  host_bus_cfg DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .wr_done_i(done), .wr_pending_i(pend),
    .queue_depth_strap_pin_i(strap), .processor_reset_out_n_o(cpu_rst_n),
    .acc_valid_i(av), .acc_addr_i(aa), .acc_decode_link_i(al), .link_valid_o(link_valid),
    .link_sel_o(link_sel), .win_hit_o(win_hit), .throttle_active_o(thr), .irq_o(irq));

  hub_far_side FAR (.ref_clk_i(ref_clk_i), .wr_done_o(done), .wr_pending_o(pend),
    .strap_o(strap), .acc_valid_o(av), .acc_addr_o(aa), .acc_link_o(al));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge ref_clk_i);
    rd <= ~we;
    wr <= we;
    adr <= a;
    wdat <= d;
    be <= be_sel;
    q = 32'h0;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (wreq === 1'b0) begin
        q = rdat;
        break;
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 20) begin
      chk(1, 0);
      end_sim();
    end
  endtask

  task automatic wait_cpu;
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge ref_clk_i);
      if (cpu_rst_n === 1'b1) break;
    end
    if (i == 200) begin
      chk(1, 0);
      end_sim();
    end
  endtask

  task automatic route(input logic [35:0] a, input logic [1:0] dec, input logic [1:0] el,
                       input logic eh);
    FAR.access(a, dec);
    @(negedge ref_clk_i);
    chk(link_valid, 1'b1);
    chk(link_sel, el);
    chk(win_hit, eh);
    @(negedge ref_clk_i);
    chk(link_valid, 1'b0);
  endtask

  initial begin
    logic [31:0] q;
    logic [1:0]  dec;
    error_cnt = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    be = 4'hF;
    be_sel = 4'hF;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    wait_cpu();
    FAR.set_strap(1'b1);
    bus(0, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    chk(q & 32'h16, 32'h4);
    bus(0, hub_cfg_pkg::OFS_STAT, 32'h0, q);
    chk(q & 32'h3, 32'h2);
    bus(0, 5'h18, 32'h0, q);
    chk(q, 32'h0);
    bus(1, hub_cfg_pkg::OFS_SLICE, 32'hFFFF, q);
    bus(1, hub_cfg_pkg::OFS_MASK, 32'h1, q);
    FAR.set_pending(1'b1);
    FAR.writes(3);
    repeat (2) @(negedge ref_clk_i);
    chk({thr, irq}, 2'b00);
    FAR.writes(1);
    repeat (2) @(negedge ref_clk_i);
    chk({thr, irq}, 2'b11);
    FAR.set_pending(1'b0);
    repeat (4) @(posedge ref_clk_i);
    bus(1, hub_cfg_pkg::OFS_CFG, 32'h10, q);
    bus(0, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    chk(q & 32'h10, 32'h10);
    be_sel = 4'h0;
    bus(1, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    be_sel = 4'hF;
    bus(0, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    chk(q & 32'h10, 32'h10);
    bus(1, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    bus(0, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    chk(q & 32'h10, 32'h0);
    bus(1, hub_cfg_pkg::OFS_STAT, 32'h3, q);
    @(negedge ref_clk_i);
    chk(irq, 1'b0);
    for (int m = 0; m < 2; m++) begin
      bus(1, hub_cfg_pkg::OFS_CFG, {30'h0, m[0], 1'b0}, q);
      for (int i = 0; i < 9; i++) begin
        dec = th[i] ? tl[i] + 2'h1 : tl[i];
        route(ta[i], dec, m[0] ? dec : tl[i], m[0] ? 1'b0 : th[i]);
      end
    end
    bus(1, hub_cfg_pkg::OFS_RSTCTL, 32'h1, q);
    @(negedge ref_clk_i);
    chk(cpu_rst_n, 1'b0);
    wait_cpu();
    bus(0, hub_cfg_pkg::OFS_CFG, 32'h0, q);
    chk(q & 32'h4, 32'h0);
    end_sim();
  end
endmodule
